// [design/adc_result_serial_output.sv]
// serial result output of a six-channel sampling converter
// assumes sck and sample_strobe come from outside the mclk domain,
// results arrive on mclk through a valid/ready handshake
//
// Function
// - output line tri-stated at reset
// - stay tri-stated until strobe rising edge
// - data starts third sck rise after strobe
// - two don't-care, two tri-state bits per slot
// - bit valid before next sck rise
// - frame of 16 to 96 bits, slots
// - each result sent msb first
// - ignore strobe until 96 sck rises
`timescale 1ns/10ps
`include "adc_result_serial_output_consts.svh"

module adc_result_serial_output #(
  parameter int DATA_BITS = `ARSO_DATA_BITS,
  parameter int MAX_CHANNELS = `ARSO_MAX_CHANNELS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sample_strobe,
  input wire logic [2:0] channel_count_select,
  input wire logic [DATA_BITS-1:0] resultData,
  input wire logic resultValid,
  output logic resultReady,
  output logic result_out_line,
  output logic resultOe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [4:0] pinRaw = {channel_count_select, sample_strobe, sck};
  wire [4:0] pinSync;

  // two flops per pin before any logic reads it
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      logic meta_q;
      logic sync_q;
      always_ff @(posedge mclk) begin
        if (!resetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= pinRaw[gi];
          sync_q <= meta_q;
        end
      end
      assign pinSync[gi] = sync_q;
    end
  endgenerate

  wire sckSync = pinSync[0];
  wire strbSync = pinSync[1];
  wire [2:0] selSync = pinSync[4:2];

  // previous synchronised levels for edge detection
  logic sckPrev_q;
  logic strbPrev_q;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sckPrev_q <= 1'b0;
      strbPrev_q <= 1'b0;
    end else begin
      sckPrev_q <= sckSync;
      strbPrev_q <= strbSync;
    end
  end

  wire sckRise = sckSync & ~sckPrev_q;
  wire strobeRise = strbSync & ~strbPrev_q;

  // select value s gives s+1 channels, clamped at the maximum
  function automatic logic [2:0] chanCount(input logic [2:0] s);
    logic [3:0] n;
    n = {1'b0, s} + 4'h1;
    if (n > 4'(MAX_CHANNELS)) begin
      n = 4'(MAX_CHANNELS);
    end
    return n[2:0];
  endfunction

  // ----------------------------------------------------------------
  // frame sequencing
  // ----------------------------------------------------------------
  adc_result_serial_output_pkg::frame_state_t state_q;
  logic [6:0] edgeCnt_q;
  logic [2:0] chans_q;
  logic [DATA_BITS-1:0] shift_q;

  wire [6:0] edgeNext = edgeCnt_q + 7'h01;
  wire [6:0] posNext = edgeNext - `ARSO_FIRST_EDGE;
  wire [2:0] slotIdx = posNext[6:4];
  wire [3:0] bitIdx = posNext[3:0];
  wire inFrame = (state_q == adc_result_serial_output_pkg::ST_FRAME);
  wire pastStart = (edgeNext >= `ARSO_FIRST_EDGE);
  wire slotLive = pastStart && (slotIdx < chans_q);
  wire isDataBit = slotLive && (bitIdx <= `ARSO_DATA_LAST_BIT);
  wire isDcBit = slotLive && (bitIdx > `ARSO_DATA_LAST_BIT) && (bitIdx <= `ARSO_DC_LAST_BIT);
  wire slotStart = isDataBit && (bitIdx == 4'h0);
  wire startOk = strobeRise && (!inFrame || (edgeCnt_q >= `ARSO_GUARD_EDGES));
  wire advance = inFrame && sckRise && !startOk && (edgeCnt_q != `ARSO_EDGE_SAT);

  // two-entry result buffer
  logic [DATA_BITS-1:0] mem_q [0:1];
  logic wrPtr_q, rdPtr_q;
  logic [1:0] cnt_q;
  wire [DATA_BITS-1:0] headWord = mem_q[rdPtr_q];
  wire headValid = (cnt_q != 2'h0);
  wire push = resultValid && resultReady;
  wire pop = advance && slotStart && headValid;
  wire [1:0] cntNext = cnt_q + {1'b0, push} - {1'b0, pop};
  // an empty buffer sends a zero word rather than stalling the frame
  wire [DATA_BITS-1:0] loadWord = headValid ? headWord : '0;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      cnt_q <= 2'h0;
      resultReady <= 1'b0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push) begin
        mem_q[wrPtr_q] <= resultData;
        wrPtr_q <= ~wrPtr_q;
      end
      if (pop) begin
        rdPtr_q <= ~rdPtr_q;
      end
      cnt_q <= cntNext;
      resultReady <= (cntNext != `ARSO_BUF_DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // output line
  // ----------------------------------------------------------------
  // msb of word first
  wire [DATA_BITS-1:0] wordNow = slotStart ? loadWord : shift_q;
  wire lineBit = isDataBit ? wordNow[DATA_BITS-1] : 1'b0;
  wire [DATA_BITS-1:0] wordShifted = {wordNow[DATA_BITS-2:0], 1'b0};
  wire driveNow = isDataBit || isDcBit;

  adc_result_serial_output_pkg::frame_state_t state_d;
  logic [6:0] edgeCnt_d;
  logic [2:0] chans_d;
  logic [DATA_BITS-1:0] shift_d;
  logic oe_d;
  logic line_d;

  always_comb begin
    state_d = state_q;
    edgeCnt_d = edgeCnt_q;
    chans_d = chans_q;
    shift_d = shift_q;
    oe_d = resultOe;
    line_d = result_out_line;
    case (state_q)
      adc_result_serial_output_pkg::ST_IDLE: begin
        if (startOk) begin
          state_d = adc_result_serial_output_pkg::ST_FRAME;
          edgeCnt_d = 7'h00;
          chans_d = chanCount(selSync);
          oe_d = 1'b0;
        end
      end
      adc_result_serial_output_pkg::ST_FRAME: begin
        if (startOk) begin
          edgeCnt_d = 7'h00;
          chans_d = chanCount(selSync);
          oe_d = 1'b0;
        end else if (advance) begin
          edgeCnt_d = edgeNext;
          line_d = lineBit;
          oe_d = driveNow;
          if (isDataBit) begin
            shift_d = wordShifted;
          end
        end else if (edgeCnt_q == `ARSO_EDGE_SAT) begin
          // counter spent: park until the next strobe
          state_d = adc_result_serial_output_pkg::ST_IDLE;
          oe_d = 1'b0;
        end
      end
      default: begin
        state_d = adc_result_serial_output_pkg::ST_IDLE;
        oe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_q <= adc_result_serial_output_pkg::ST_IDLE;
      edgeCnt_q <= 7'h00;
      chans_q <= 3'h0;
      shift_q <= '0;
      resultOe <= 1'b0;
      result_out_line <= 1'b0;
    end else begin
      state_q <= state_d;
      edgeCnt_q <= edgeCnt_d;
      chans_q <= chans_d;
      shift_q <= shift_d;
      resultOe <= oe_d;
      result_out_line <= line_d;
    end
  end

endmodule // adc_result_serial_output

// [design/adc_result_serial_output_consts.svh]
// constants for the serial result output block
// assumes inclusion by bare name from the design files
`ifndef ADC_RESULT_SERIAL_OUTPUT_CONSTS_SVH
`define ADC_RESULT_SERIAL_OUTPUT_CONSTS_SVH

`define ARSO_DATA_BITS 12
`define ARSO_SLOT_BITS 16
`define ARSO_MAX_CHANNELS 6
`define ARSO_FIRST_EDGE 7'h03
`define ARSO_GUARD_EDGES 7'h60
`define ARSO_DC_LAST_BIT 4'hd
`define ARSO_DATA_LAST_BIT 4'hb
`define ARSO_EDGE_SAT 7'h7f
`define ARSO_BUF_DEPTH 2'h2

`endif

// [design/adc_result_serial_output_pkg.sv]
// types for the serial result output block
// assumes nothing beyond the constants header
package adc_result_serial_output_pkg;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_FRAME = 1'b1
  } frame_state_t;
endpackage

// [verification/adc_result_serial_output_props.sv]
// checker on the result output ports
// assumes an sck period of 8 mclk cycles
`timescale 1ns/10ps
module adc_result_serial_output_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic sample_strobe,
  input wire logic resultValid,
  input wire logic resultReady,
  input wire logic result_out_line,
  input wire logic resultOe
);
  logic k_q, s_q;
  logic [6:0] r_q;
  // sck rises since the last accepted strobe, 7f means idle
  wire go = sample_strobe && !s_q && r_q > 7'h5f;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  always_ff @(posedge mclk) begin
    k_q <= sck;
    s_q <= sample_strobe;
    r_q <= !resetn ? 7'h7f : go ? 7'h00 : r_q + 7'(sck && !k_q && r_q < 7'h7f);
  end
  reset_hiz_a: assert property ($rose(resetn) |-> !resultOe) else $error("oe at reset");
  ready_up_a: assert property ($rose(resetn) |=> resultReady) else $error("not ready");
  idle_hiz_a: assert property (r_q == 7'h7f |-> !resultOe) else $error("oe while idle");
  lead_hiz_a: assert property (r_q < 7'h03 |-> !resultOe) else $error("oe too early");
  first_bit_a: assert property (r_q == 7'h03 && $changed(r_q) |-> ##[1:5] resultOe) else $error("no data");
  sck_paced_a: assert property ($changed({resultOe, result_out_line}) |-> $past(sck, 2)) else $error("off sck");
  slot_gap_a: assert property ($fell(resultOe) |-> (!resultOe)[*8] ##7 !resultOe) else $error("short gap");
  buf_full_a: assert property ((!sck)[*5] ##0 (resultValid && resultReady)[*2] |=> !resultReady) else $error("overfill");
  cover property (r_q == 7'h60);
  cover property (resultValid && !resultReady);
  cover property ($fell(resultOe));
endmodule // adc_result_serial_output_props

bind adc_result_serial_output adc_result_serial_output_props props_inst (
  .mclk(mclk),
  .resetn(resetn),
  .sck(sck),
  .sample_strobe(sample_strobe),
  .resultValid(resultValid),
  .resultReady(resultReady),
  .result_out_line(result_out_line),
  .resultOe(resultOe)
);

// [verification/host_port.sv]
// host serial port model: makes sck and strobe, samples the line
// assumes frame() is entered on a falling mclk edge
`timescale 1ns/10ps
module host_port (
  output logic sck = 1'b0,
  output logic sample_strobe = 1'b0,
  input wire logic result_out_line,
  input wire logic resultOe
);
  logic [127:0] cap, drv;
  // 100 sck per frame, sampled on the fall
  task automatic frame(input int again);
    sample_strobe = 1'b1;
    #80 sample_strobe = 1'b0;
    for (int r = 1; r <= 100; r++) begin
      #80 sck = 1'b1;
      #80 sck = 1'b0;
      drv[r] = resultOe;
      cap[r] = resultOe ? result_out_line : ~cap[r - 1];
      sample_strobe = 1'(r == again);
    end
  endtask
endmodule // host_port

// [verification/tb.sv]
// bench for the result output block
// assumes host_port and the bound checker
`timescale 1ns/10ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] channel_count_select = 3'h0;
  logic sck, sample_strobe, resultReady, result_out_line, resultOe;
  int idx = 0, nWords = 0, error_cnt = 0, check_count = 0;
  wire resultValid = idx < nWords;
  wire [11:0] resultData = 12'(idx * 12'h2d9 + 12'h80d);
  adc_result_serial_output adc_result_serial_output_inst (
    .mclk(mclk),
    .resetn(resetn),
    .sck(sck),
    .sample_strobe(sample_strobe),
    .channel_count_select(channel_count_select),
    .resultData(resultData),
    .resultValid(resultValid),
    .resultReady(resultReady),
    .result_out_line(result_out_line),
    .resultOe(resultOe)
  );
  host_port host_port_inst (
    .sck(sck),
    .sample_strobe(sample_strobe),
    .result_out_line(result_out_line),
    .resultOe(resultOe)
  );
  // word taken on the rising edge, next word offered at the falling edge
  logic took = 1'b0;
  always @(posedge mclk) took <= resultValid && resultReady;
  always @(negedge mclk) if (took) idx <= idx + 1;
  initial forever #10 mclk = ~mclk;
  task automatic chk(input logic [11:0] got, exp);
    check_count++;
    if (got !== exp) $display("CHECK FAILED %0t %h %h", $time, got, exp);
    if (got !== exp) error_cnt++;
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_frames();
    int c, p, b;
    logic [11:0] w;
    for (int s = 0; s < 8; s++) begin
      c = s > 5 ? 6 : s + 1;
      channel_count_select = 3'(s);
      b = idx;
      nWords = b + c;
      repeat (9) @(negedge mclk);
      if (c > 2) chk(12'({idx - b, resultReady}), 12'h004);
      host_port_inst.frame(40);
      for (int r = 1; r < 99; r++) begin
        p = r - 3;
        w = 12'((b + p / 16) * 12'h2d9 + 12'h80d);
        chk(host_port_inst.drv[r], 12'(p >= 0 && p < c * 16 && p % 16 < 14));
        if (host_port_inst.drv[r]) chk(host_port_inst.cap[r], 12'(p % 16 < 12 && w[11 - p % 16]));
      end
    end
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    chk({resultOe, resultReady}, 12'h000);
    resetn = 1'b1;
    t_frames();
    wrap_up();
  end
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
endmodule // tb
